// ### hw/nfp_defines.vh
`ifndef NFP_DEFINES_VH
`define NFP_DEFINES_VH
// ****************************************
// operation codes on the user port
// ****************************************
`define NFP_OP_CMD     2'h0
`define NFP_OP_ADDR    2'h1
`define NFP_OP_WRITE   2'h2
`define NFP_OP_READ    2'h3
// ****************************************
// timing
// ****************************************
`define NFP_CLK_HZ       10000000
`define NFP_STROBE_NS    200
`define NFP_STROBE_CYC   ((`NFP_STROBE_NS * (`NFP_CLK_HZ / 1000000) + 999) / 1000)
`define NFP_CS_COUNT     8
`define NFP_CS_IDLE      8'hFF
`endif

// ### hw/nfp_skid_buf.v
// ****************************************
// two-entry buffer, valid/ready both sides
// ****************************************
module nfp_skid_buf #(
   parameter WIDTH = 8
) (
   input  wire             clk,
   input  wire             rst,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg  [WIDTH-1:0] mem_ff [0:1];
   reg              wr_ptr_ff;
   reg              rd_ptr_ff;
   reg  [1:0]       cnt_ff;
   wire             push;
   wire             pop;

   assign in_ready  = (cnt_ff != 2'h2);
   assign out_valid = (cnt_ff != 2'h0);
   assign out_data  = mem_ff[rd_ptr_ff];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         cnt_ff    <= 2'h0;
         mem_ff[0] <= {WIDTH{1'b0}};
         mem_ff[1] <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
            wr_ptr_ff         <= ~wr_ptr_ff;
         end
         if (pop)
            rd_ptr_ff <= ~rd_ptr_ff;
         if (push & ~pop)
            cnt_ff <= cnt_ff + 2'h1;
         else if (pop & ~push)
            cnt_ff <= cnt_ff - 2'h1;
      end
   end
endmodule // nfp_skid_buf

// ### hw/nfp_port_ctrl.v
`include "nfp_defines.vh"

// Operation
// R1: commands, addresses and data share one 8-bit two-way flash bus
// R2: selected flash ready/busy line low means busy, high means ready
// R3: command cycle holds command qualifier high; flash latches on strobe rise
// R4: address cycle holds address qualifier high; flash latches on strobe rise
// R5: flash drives data and steps column on each read strobe fall
// R6: target flash chosen by its active-low chip select among eight
// R7: activity lamp driven low during transfer, released after it
// R8: alive lamp driven low only while powered and initialised
// R9: protect switch low reports protection, drives flash protect low, blocks config writes
// R10: switch low mid-transfer: finish work, then assert flash protect
// R11: low reset held 10 ms returns device to reset state; here rst is active high and resets at once, with no hold time
// R12: board supplies 24 MHz reference within 100 ppm; NFP_CLK_HZ here assumes a 10 MHz clock
// R13: at most one chip select active at once
// R14: bus and qualifiers stable through write strobe low phase and rise
module nfp_port_ctrl #(
   parameter STROBE_CYC = `NFP_STROBE_CYC
) (
   input  wire       clk,
   input  wire       rst,
   // user request port
   input  wire [1:0] req_op,
   input  wire [2:0] req_cs,
   input  wire [7:0] req_data,
   input  wire       req_config,
   input  wire       req_valid,
   output wire       req_ready,
   output reg        req_refused_ff,
   // read data out through the buffer
   output wire [7:0] rd_data,
   output wire       rd_valid,
   input  wire       rd_ready,
   output reg        media_protected_ff,
   output reg        flash_ready_ff,
   // flash pins
   input  wire [7:0] flash_io_in,
   output reg  [7:0] flash_io_out_ff,
   output reg        flash_io_oe_n_ff,
   output reg        cmd_latch_ff,
   output reg        addr_latch_ff,
   output reg        write_strobe_n_ff,
   output reg  [1:0] read_strobe_n_ff,
   output reg  [7:0] chip_sel_n_ff,
   input  wire [1:0] ready_busy_n,
   output reg        activity_lamp_n_ff,
   output reg        activity_lamp_oe_n_ff,
   output reg        alive_lamp_n_ff,
   output reg        alive_lamp_oe_n_ff,
   output reg        flash_protect_out_n_ff,
   input  wire       protect_switch_n
);
   // ****************************************
   // state machine
   // ****************************************
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_LOW  = 5'h02;
   localparam [4:0] ST_HIGH = 5'h04;
   localparam [4:0] ST_PUSH = 5'h08;
   localparam [4:0] ST_INIT = 5'h10;

   reg  [4:0] state_ff;
   reg  [7:0] cnt_ff;
   reg  [1:0] op_ff;
   reg  [1:0] rb_s1_ff;
   reg  [1:0] rb_s2_ff;
   reg        sw_s1_ff;
   reg        sw_s2_ff;
   reg  [7:0] cap_ff;
   reg        cap_valid_ff;
   wire       buf_in_ready;
   wire       take;
   wire       sel_hi;
   wire       rb_sel;

   // ****************************************
   // two-stage sync for the ready/busy and protect switch pins
   // ****************************************
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rb_s1_ff <= 2'h3;
         rb_s2_ff <= 2'h3;
         sw_s1_ff <= 1'b1;
         sw_s2_ff <= 1'b1;
      end else begin
         rb_s1_ff <= ready_busy_n;
         rb_s2_ff <= rb_s1_ff;
         sw_s1_ff <= protect_switch_n;
         sw_s2_ff <= sw_s1_ff;
      end
   end

   // ****************************************
   // busy line and strobe group select
   // ****************************************
   // chips 0..3 sit on busy line 0 and read strobe 0, chips 4..7 on busy line 1 and read strobe 1
   assign sel_hi    = ~chip_sel_n_ff[0] | ~chip_sel_n_ff[1] | ~chip_sel_n_ff[2] |
                      ~chip_sel_n_ff[3] ? 1'b0 : 1'b1;
   assign rb_sel    = sel_hi ? rb_s2_ff[1] : rb_s2_ff[0]; // [R2]
   assign req_ready = (state_ff == ST_IDLE) & rb_sel;
   assign take      = req_valid & req_ready;

   // ****************************************
   // transfer sequencer
   // ****************************************
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff               <= ST_INIT;
         cnt_ff                 <= 8'h00;
         op_ff                  <= 2'h0;
         flash_io_out_ff        <= 8'h00;
         flash_io_oe_n_ff       <= 1'b1;
         cmd_latch_ff           <= 1'b0;
         addr_latch_ff          <= 1'b0;
         write_strobe_n_ff      <= 1'b1;
         read_strobe_n_ff       <= 2'h3;
         chip_sel_n_ff          <= `NFP_CS_IDLE;
         activity_lamp_n_ff     <= 1'b1;
         activity_lamp_oe_n_ff  <= 1'b1;
         alive_lamp_n_ff        <= 1'b1;
         alive_lamp_oe_n_ff     <= 1'b1;
         flash_protect_out_n_ff <= 1'b1;
         media_protected_ff     <= 1'b0;
         req_refused_ff         <= 1'b0;
         flash_ready_ff         <= 1'b0;
         cap_ff                 <= 8'h00;
         cap_valid_ff           <= 1'b0;
      end else begin
         flash_ready_ff     <= rb_sel;
         media_protected_ff <= ~sw_s2_ff; // [R9]
         req_refused_ff     <= 1'b0;
         if (cap_valid_ff & buf_in_ready)
            cap_valid_ff <= 1'b0;
         case (state_ff)
            ST_INIT: begin
               // reset released: device is powered and initialised
               alive_lamp_n_ff    <= 1'b0; // [R8]
               alive_lamp_oe_n_ff <= 1'b0; // [R8]
               state_ff           <= ST_IDLE; // [R11]
            end
            ST_IDLE: begin
               activity_lamp_n_ff    <= 1'b1; // [R7]
               activity_lamp_oe_n_ff <= 1'b1; // [R7]
               flash_io_oe_n_ff      <= 1'b1;
               cmd_latch_ff          <= 1'b0;
               addr_latch_ff         <= 1'b0;
               // protect only asserted between transfers, never mid-operation
               flash_protect_out_n_ff <= sw_s2_ff; // [R9] [R10]
               if (take && req_op == `NFP_OP_WRITE && req_config && !sw_s2_ff) begin
                  req_refused_ff <= 1'b1; // [R9]
               end else if (take) begin
                  op_ff         <= req_op;
                  chip_sel_n_ff <= ~(8'h01 << req_cs); // [R6] [R13]
                  activity_lamp_n_ff    <= 1'b0; // [R7]
                  activity_lamp_oe_n_ff <= 1'b0; // [R7]
                  cmd_latch_ff  <= (req_op == `NFP_OP_CMD); // [R3]
                  addr_latch_ff <= (req_op == `NFP_OP_ADDR); // [R4]
                  flash_io_out_ff  <= req_data; // [R1]
                  flash_io_oe_n_ff <= (req_op == `NFP_OP_READ); // [R1]
                  cnt_ff   <= 8'h00;
                  state_ff <= ST_LOW;
               end
            end
            ST_LOW: begin
               // bus and qualifiers already settled one cycle before strobe falls
               if (op_ff == `NFP_OP_READ)
                  read_strobe_n_ff <= req_cs_strobe(chip_sel_n_ff); // [R5]
               else
                  write_strobe_n_ff <= 1'b0; // [R14]
               if (cnt_ff == STROBE_CYC[7:0]) begin
                  cnt_ff   <= 8'h00;
                  state_ff <= ST_HIGH;
               end else
                  cnt_ff <= cnt_ff + 8'h01;
            end
            ST_HIGH: begin
               write_strobe_n_ff <= 1'b1; // [R3] [R4] [R14]
               read_strobe_n_ff  <= 2'h3;
               if (op_ff == `NFP_OP_READ) begin
                  cap_ff       <= flash_io_in; // [R5]
                  cap_valid_ff <= 1'b1;
               end
               state_ff <= ST_PUSH;
            end
            ST_PUSH: begin
               // stall here until the buffer took the read byte
               if (!cap_valid_ff || buf_in_ready) begin
                  chip_sel_n_ff <= `NFP_CS_IDLE; // [R13]
                  state_ff      <= ST_IDLE;
                  // lamp goes dark with the transfer, on the same edge that ready shows again
                  activity_lamp_n_ff    <= 1'b1; // [R7]
                  activity_lamp_oe_n_ff <= 1'b1; // [R7]
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // read strobe group of the selected chip
   // ****************************************
   function [1:0] req_cs_strobe;
      input [7:0] cs_n;
      begin
         req_cs_strobe = (&cs_n[3:0]) ? 2'h1 : 2'h2;
      end
   endfunction

   // ****************************************
   // read data buffer, absorbs a stalled receiver
   // ****************************************
   nfp_skid_buf #(
      .WIDTH (8)
   ) u_rd_buf (
      .clk       (clk),
      .rst       (rst),
      .in_data   (cap_ff),
      .in_valid  (cap_valid_ff),
      .in_ready  (buf_in_ready),
      .out_data  (rd_data),
      .out_valid (rd_valid),
      .out_ready (rd_ready)
   );
endmodule // nfp_port_ctrl

// ### verif/nfp_port_ctrl_chk.sv
// ****
// port behaviour watched at the pins
// ****
module nfp_port_ctrl_chk (
   input logic       clk,
   input logic       rst,
   input logic [1:0] req_op,
   input logic       req_config,
   input logic       req_valid,
   input logic       req_ready,
   input logic       req_refused_ff,
   input logic       media_protected_ff,
   input logic       flash_ready_ff,
   input logic [7:0] flash_io_out_ff,
   input logic       flash_io_oe_n_ff,
   input logic       cmd_latch_ff,
   input logic       addr_latch_ff,
   input logic       write_strobe_n_ff,
   input logic [7:0] chip_sel_n_ff,
   input logic       activity_lamp_n_ff,
   input logic       activity_lamp_oe_n_ff,
   input logic       alive_lamp_oe_n_ff,
   input logic       flash_protect_out_n_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_one_select: assert property ($onehot0(~chip_sel_n_ff))
      else $error("more than one chip select low");
   a_bus_driven: assert property (
      !write_strobe_n_ff |-> !flash_io_oe_n_ff && chip_sel_n_ff != 8'hFF)
      else $error("strobe without bus drive or select");
   a_strobe_stable: assert property (
      !write_strobe_n_ff |=> $stable({flash_io_out_ff, cmd_latch_ff, addr_latch_ff}))
      else $error("bus or qualifier moved under strobe");
   a_ready_busy: assert property (req_ready |=> flash_ready_ff)
      else $error("request accepted while flash busy");
   a_lamp_on: assert property (
      !write_strobe_n_ff |-> !activity_lamp_oe_n_ff && !activity_lamp_n_ff)
      else $error("activity lamp dark during transfer");
   a_lamp_off: assert property (req_ready |-> activity_lamp_oe_n_ff)
      else $error("activity lamp driven while idle");
   a_alive_lamp: assert property (!$past(rst) |-> !alive_lamp_oe_n_ff)
      else $error("alive lamp not driven after init");
   a_protect_hold: assert property (
      !write_strobe_n_ff |=> $stable(flash_protect_out_n_ff))
      else $error("flash protect moved mid transfer");
   a_cfg_refused: assert property (
      req_valid && req_ready && req_op == 2'h2 && req_config && media_protected_ff
      |=> req_refused_ff)
      else $error("config write not refused");
endmodule // nfp_port_ctrl_chk

// ### verif/nfp_flash_model.sv
// ****
// behavioural flash array on the far side
// ****
module nfp_flash_model (
   input  logic       clk,
   input  logic [7:0] io,
   input  logic [7:0] cs_n,
   input  logic       cle,
   input  logic       ale,
   input  logic       we_n,
   input  logic [1:0] re_n,
   input  logic [7:0] busy_len,
   output logic [7:0] io_q,
   output logic [1:0] rb_n,
   output logic [7:0] got_cs,
   output logic [7:0] got_cmd,
   output logic [7:0] got_addr,
   output logic [7:0] got_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] col = 8'h00;
   logic [7:0] busy_cnt = 8'h00;
   initial io_q = 8'h5A;
   assign rb_n = {2{busy_cnt == 8'h00}};
   always @(posedge clk) if (busy_cnt != 8'h00) busy_cnt <= busy_cnt - 8'h01;
   always @(posedge we_n) if (cs_n != 8'hFF) begin
      got_cs <= cs_n;
      if (cle) begin
         got_cmd <= io;
         busy_cnt <= busy_len;
      end else if (ale) begin
         got_addr <= io;
         col <= 8'h00;
      end else got_data <= io;
   end
   always @(negedge (&re_n)) begin
      io_q <= 8'hA0 + col;
      col <= col + 8'h01;
   end
   // released bus must not keep showing the old byte
   always @(posedge (&re_n)) io_q <= ~io_q;
endmodule // nfp_flash_model

// ### verif/nfp_port_ctrl_test.sv
`include "nfp_defines.vh"
module nfp_port_ctrl_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, req_valid = 0, req_config = 0, rd_ready = 0, protect_switch_n = 1;
   logic [1:0] req_op = 2'h0, read_strobe_n_ff, ready_busy_n;
   logic [2:0] req_cs = 3'h0;
   logic [7:0] req_data = 8'h00, busy_len = 8'h14, fl_q, got_cs, got_cmd, got_addr, got_data;
   logic [7:0] flash_io_in, flash_io_out_ff, chip_sel_n_ff, rd_data;
   logic req_ready, req_refused_ff, rd_valid, media_protected_ff, flash_ready_ff, flash_io_oe_n_ff;
   logic cmd_latch_ff, addr_latch_ff, write_strobe_n_ff, activity_lamp_n_ff, activity_lamp_oe_n_ff;
   logic alive_lamp_n_ff, alive_lamp_oe_n_ff, flash_protect_out_n_ff, refused_seen = 0;
   int errors = 0, check_count = 0;
   always #50 clk = ~clk;
   assign flash_io_in = flash_io_oe_n_ff ? fl_q : flash_io_out_ff;
   always @(posedge clk) if (req_refused_ff) refused_seen <= 1'b1;
   nfp_port_ctrl nfp_port_ctrl_i (.*);
   nfp_flash_model nfp_flash_model_i (.clk(clk), .io(flash_io_out_ff), .cs_n(chip_sel_n_ff),
      .cle(cmd_latch_ff), .ale(addr_latch_ff), .we_n(write_strobe_n_ff), .re_n(read_strobe_n_ff),
      .busy_len(busy_len), .io_q(fl_q), .rb_n(ready_busy_n), .got_cs(got_cs), .got_cmd(got_cmd),
      .got_addr(got_addr), .got_data(got_data));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic wait_idle;
      int n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (req_ready !== 1'b1 && n < 300);
      if (n == 300) errors++;
   endtask
   task automatic req(input logic [1:0] op, input logic [2:0] cs, input logic [7:0] d,
                      input logic cfg);
      @(posedge clk);
      req_op <= op;
      req_cs <= cs;
      req_data <= d;
      req_config <= cfg;
      req_valid <= 1'b1;
      // hold the request until ready stands high ahead of the taking edge
      wait_idle();
      @(posedge clk);
      req_valid <= 1'b0;
      wait_idle();
   endtask
   task automatic pop(input logic [7:0] exp);
      @(negedge clk);
      chk({7'h0, rd_valid}, 8'h01);
      chk(rd_data, exp);
      @(posedge clk);
      rd_ready <= 1'b1;
      @(posedge clk);
      rd_ready <= 1'b0;
   endtask
   task automatic t_cmd_addr;
      for (int c = 0; c < 8; c++) begin
         req(`NFP_OP_CMD, c[2:0], 8'h30 + c[7:0], 1'b0);
         chk(got_cmd, 8'h30 + c[7:0]);
         chk(got_cs, ~(8'h01 << c));
         repeat (3) @(negedge clk);
         chk({7'h0, flash_ready_ff}, 8'h00);
         req(`NFP_OP_ADDR, c[2:0], 8'h10 + c[7:0], 1'b0);
         chk(got_addr, 8'h10 + c[7:0]);
      end
   endtask
   task automatic t_write_read;
      busy_len <= 8'h00;
      req(`NFP_OP_WRITE, 3'h3, 8'hC3, 1'b0);
      chk(got_data, 8'hC3);
      chk({7'h0, activity_lamp_oe_n_ff}, 8'h01);
      req(`NFP_OP_ADDR, 3'h5, 8'h00, 1'b0);
      req(`NFP_OP_READ, 3'h5, 8'h00, 1'b0);
      req(`NFP_OP_READ, 3'h5, 8'h00, 1'b0);
      pop(8'hA0);
      pop(8'hA1);
      @(negedge clk);
      chk({7'h0, rd_valid}, 8'h00);
   endtask
   task automatic t_protect;
      fork
         req(`NFP_OP_WRITE, 3'h2, 8'h5C, 1'b0);
         begin
            repeat (3) @(posedge clk);
            protect_switch_n <= 1'b0;
            repeat (3) @(negedge clk);
            chk({7'h0, flash_protect_out_n_ff}, 8'h01);
         end
      join
      repeat (4) @(negedge clk);
      chk(got_data, 8'h5C);
      chk({7'h0, flash_protect_out_n_ff}, 8'h00);
      chk({7'h0, media_protected_ff}, 8'h01);
      req(`NFP_OP_WRITE, 3'h2, 8'h77, 1'b1);
      chk({7'h0, req_refused_ff}, 8'h01);
      chk(got_data, 8'h5C);
      @(negedge clk);
      chk({7'h0, refused_seen}, 8'h01);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(negedge clk);
      chk({7'h0, alive_lamp_oe_n_ff}, 8'h00);
      chk({7'h0, alive_lamp_n_ff}, 8'h00);
      t_cmd_addr();
      t_write_read();
      t_protect();
      end_sim();
   end
   initial begin
      #2000000;
      errors++;
      end_sim();
   end
endmodule // nfp_port_ctrl_test
bind nfp_port_ctrl nfp_port_ctrl_chk nfp_port_ctrl_chk_i (.*);
